// >>> verilog/ucaid_defines.svh
// Register map, reset values and baud constants of the UART control block
`ifndef UCAID_DEFINES_SVH
`define UCAID_DEFINES_SVH

`define UCAID_ADDR_W 8
`define UCAID_DATA_W 32

`define UCAID_OFF_CTRL 8'h00
`define UCAID_OFF_CFG 8'h04
`define UCAID_OFF_DIV 8'h08
`define UCAID_OFF_STAT 8'h0C
`define UCAID_OFF_MASK 8'h10
`define UCAID_OFF_RXD 8'h14
`define UCAID_OFF_FLAGS 8'h18

`define UCAID_CTRL_RST 6'h00
`define UCAID_CFG_RST 1'h0
`define UCAID_DIV_RST 8'h00
`define UCAID_STAT_RST 6'h00
`define UCAID_MASK_RST 6'h00

`define UCAID_LOW_MULT 7'h40
`define UCAID_HIGH_MULT 7'h10

`endif

// >>> verilog/ucaid_pkg.sv
// Types shared by the UART control block
package ucaid_pkg;

   // Second control register, low six bits, msb first
   typedef struct packed {
      logic baud_high_speed_sel;
      logic address_detect_en;
      logic wake_en;
      logic rx_irq_en;
      logic tx_idle_irq_en;
      logic tx_empty_irq_en;
   } ucaid_ctrl_t;

   // Sticky event layout, shared by status and mask
   typedef struct packed {
      logic wake;
      logic addr_word;
      logic overrun;
      logic rx_avail;
      logic tx_idle;
      logic tx_empty;
   } ucaid_evt_t;

   typedef struct packed {
      logic rx_bit_nine;
      logic [7:0] data;
   } ucaid_word_t;

endpackage

// >>> verilog/ucaid_baud.sv
// Bit-rate tick generator for the UART control block
`timescale 1ns/1ps
`include "ucaid_defines.svh"

module ucaid_baud #(
   parameter int DIV_W = 8
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic high_speed,
   input wire logic [DIV_W-1:0] divisor,
   input wire logic restart,
   output logic bit_tick
);
   localparam int CNT_W = DIV_W + 7;

   logic [CNT_W-1:0] count;
   logic [CNT_W-1:0] divp1;
   logic [CNT_W-1:0] mult;
   logic [CNT_W-1:0] limit;

   generate
      if (DIV_W < 1 || DIV_W > 16)
      begin : g_bad_width
         $error("ucaid_baud: DIV_W out of range");
      end
   endgenerate

   always_comb
   begin
      divp1 = CNT_W'(divisor) + CNT_W'(1);
      mult = high_speed ? CNT_W'(`UCAID_HIGH_MULT) : CNT_W'(`UCAID_LOW_MULT);
      limit = CNT_W'(divp1 * mult) - CNT_W'(1);
   end

   // Restart on new settings so a shortened period never waits a full wrap
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
         count <= '0;
      else if (restart || count >= limit)
         count <= '0;
      else
         count <= count + CNT_W'(1);
   end

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
         bit_tick <= 1'b0;
      else
         bit_tick <= !restart && count >= limit;
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);

   logic [CNT_W:0] gap;
   logic settled;
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         gap <= '0;
         settled <= 1'b0;
      end
      else
      begin
         gap <= bit_tick ? (CNT_W+1)'(1) : gap + (CNT_W+1)'(1);
         settled <= restart ? 1'b0 : (bit_tick ? 1'b1 : settled);
      end
   end

   property p_baud_period;
      bit_tick && settled && $stable(limit) |-> gap == {1'b0, limit} + (CNT_W+1)'(1);
   endproperty
   a_baud_period: assert property (p_baud_period) else $error("bit period wrong");

   // New settings show one cycle after the restart, and the first tick needs sixteen quiet cycles
   property p_baud_fast;
      restart ##1 (high_speed && divisor == '0 && !restart) [*8] ##1 (high_speed && divisor == '0 && !restart) [*8]
         |=> bit_tick;
   endproperty
   a_baud_fast: assert property (p_baud_fast) else $error("no tick at fastest rate");

endmodule

// >>> verilog/ucaid_rx_filter.sv
// Address-detect filter on received words
`timescale 1ns/1ps

module ucaid_rx_filter (
   input wire logic clock,
   input wire logic nrst,
   input wire logic word_valid,
   input wire ucaid_pkg::ucaid_word_t word_in,
   input wire logic nine_bit_sel,
   input wire logic address_detect_en,
   output logic deliver_valid,
   output ucaid_pkg::ucaid_word_t deliver_word,
   output logic addr_pulse
);
   logic addr_bit;
   logic drop;

   always_comb
   begin
      addr_bit = nine_bit_sel ? word_in.rx_bit_nine : word_in.data[7];
      drop = address_detect_en && !addr_bit;
   end

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         deliver_valid <= 1'b0;
         addr_pulse <= 1'b0;
      end
      else
      begin
         deliver_valid <= word_valid && !drop;
         addr_pulse <= word_valid && address_detect_en && addr_bit;
      end
   end

   // Eight-bit words carry no ninth bit, so it is forced low
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
         deliver_word <= '0;
      else if (word_valid && !drop)
      begin
         deliver_word.data <= word_in.data;
         deliver_word.rx_bit_nine <= nine_bit_sel && word_in.rx_bit_nine;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);

   property p_drop_data;
      word_valid && address_detect_en && !(nine_bit_sel ? word_in.rx_bit_nine : word_in.data[7])
         |=> !deliver_valid && !addr_pulse;
   endproperty
   a_drop_data: assert property (p_drop_data) else $error("non-address word not discarded");

   property p_addr_word;
      word_valid && address_detect_en && (nine_bit_sel ? word_in.rx_bit_nine : word_in.data[7])
         |=> addr_pulse && deliver_valid;
   endproperty
   a_addr_word: assert property (p_addr_word) else $error("address word not flagged");

   property p_nine_clear;
      word_valid && !nine_bit_sel |=> deliver_valid -> !deliver_word.rx_bit_nine;
   endproperty
   a_nine_clear: assert property (p_nine_clear) else $error("ninth bit kept in 8-bit mode");

endmodule

// >>> verilog/ucaid_top.sv
// UART second-control-register logic: baud select, address detect, wake-up, interrupts
//
// What this block does
// - The high-speed select bit and the divisor together set the bit rate, one meaning high and zero low speed.
// - One bit period lasts 64 times (divisor plus one) clocks at low speed and 16 times at high speed.
// - The nine-bit select picks 8-bit words when clear and 9-bit words when set, the ninth bit kept apart.
// - With address detect on, a word is an address when bit eight (8-bit mode) or bit nine (9-bit mode) is one.
// - With address detect, the receive interrupt enable and the addr_word mask bit on, every address word raises an interrupt request.
// - With address detect on, a word whose address bit is zero raises nothing and is thrown away.
// - With wake enabled in idle-zero or sleep, a falling edge on the receive pin wakes the device.
// - With wake disabled, no edge on the receive pin wakes the device.
// - With the idle enable and its mask bit set, the transmitter idle flag setting raises the request, else not.
// - With the empty enable and its mask bit set, the transmit-empty flag setting raises the request, else not.
`timescale 1ns/1ps
`include "ucaid_defines.svh"

module ucaid_top #(
   parameter int DIV_W = 8
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`UCAID_ADDR_W-1:0] paddr,
   input wire logic [`UCAID_DATA_W-1:0] pwdata,
   output logic [`UCAID_DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rx_pin,
   input wire logic low_power_state,
   input wire logic rx_word_valid,
   input wire ucaid_pkg::ucaid_word_t rx_word,
   input wire logic rx_avail_flag,
   input wire logic overrun_flag,
   input wire logic tx_idle_flag,
   input wire logic tx_empty_flag,
   output logic baud_tick,
   output logic nine_bit_sel,
   output logic deliver_valid,
   output ucaid_pkg::ucaid_word_t deliver_word,
   output logic wake_req,
   output logic uart_irq
);
   localparam int EVT_W = $bits(ucaid_pkg::ucaid_evt_t);

   generate
      if (DIV_W != 8)
      begin : g_bad_div
         $error("ucaid_top: divisor register is one byte wide");
      end
   endgenerate

   ucaid_pkg::ucaid_ctrl_t uart_control_second;
   ucaid_pkg::ucaid_evt_t status;
   ucaid_pkg::ucaid_evt_t mask;
   ucaid_pkg::ucaid_evt_t events;
   ucaid_pkg::ucaid_evt_t enables;
   ucaid_pkg::ucaid_evt_t rd_clear;
   ucaid_pkg::ucaid_evt_t next_status;
   logic [DIV_W-1:0] baud_divisor;
   logic [3:0] flags_prev;
   logic [1:0] rx_sync;
   logic rx_last;
   logic rx_fall;
   logic addr_pulse;
   logic setup;
   logic access;
   logic wr;
   logic rd;
   logic mapped;
   logic baud_restart;
   logic [`UCAID_DATA_W-1:0] next_rdata;

   ////////////////////////////////////////////////////////////////////////////
   // APB slave, zero wait states; read data captured in the setup cycle

   always_comb
   begin
      setup = psel && !penable;
      access = psel && penable;
      wr = access && pwrite;
      rd = access && !pwrite;
      pready = access;
      mapped = paddr == `UCAID_OFF_CTRL || paddr == `UCAID_OFF_CFG || paddr == `UCAID_OFF_DIV
         || paddr == `UCAID_OFF_STAT || paddr == `UCAID_OFF_MASK || paddr == `UCAID_OFF_RXD
         || paddr == `UCAID_OFF_FLAGS;
      next_rdata = '0;
      unique case (paddr)
         `UCAID_OFF_CTRL: next_rdata = `UCAID_DATA_W'(uart_control_second);
         `UCAID_OFF_CFG: next_rdata = `UCAID_DATA_W'(nine_bit_sel);
         `UCAID_OFF_DIV: next_rdata = `UCAID_DATA_W'(baud_divisor);
         `UCAID_OFF_STAT: next_rdata = `UCAID_DATA_W'(status);
         `UCAID_OFF_MASK: next_rdata = `UCAID_DATA_W'(mask);
         `UCAID_OFF_RXD: next_rdata = `UCAID_DATA_W'(deliver_word);
         `UCAID_OFF_FLAGS: next_rdata = `UCAID_DATA_W'({tx_empty_flag, tx_idle_flag, overrun_flag, rx_avail_flag});
         default: next_rdata = '0;
      endcase
   end

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         prdata <= '0;
         pslverr <= 1'b0;
      end
      else if (setup)
      begin
         prdata <= pwrite ? '0 : next_rdata;
         pslverr <= !mapped;
      end
   end

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         uart_control_second <= `UCAID_CTRL_RST;
         nine_bit_sel <= `UCAID_CFG_RST;
         baud_divisor <= `UCAID_DIV_RST;
         mask <= `UCAID_MASK_RST;
      end
      else if (wr)
      begin
         if (paddr == `UCAID_OFF_CTRL)
            uart_control_second <= pwdata[EVT_W-1:0];
         if (paddr == `UCAID_OFF_CFG)
            nine_bit_sel <= pwdata[0];
         if (paddr == `UCAID_OFF_DIV)
            baud_divisor <= pwdata[DIV_W-1:0];
         if (paddr == `UCAID_OFF_MASK)
            mask <= pwdata[EVT_W-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Baud generator, restarted when its settings are rewritten

   assign baud_restart = wr && (paddr == `UCAID_OFF_DIV || paddr == `UCAID_OFF_CTRL);

   ucaid_baud #(
      .DIV_W(DIV_W)
   ) u_baud (
      .clock(clock),
      .nrst(nrst),
      .high_speed(uart_control_second.baud_high_speed_sel),
      .divisor(baud_divisor),
      .restart(baud_restart),
      .bit_tick(baud_tick)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Address-detect filter

   ucaid_rx_filter u_filter (
      .clock(clock),
      .nrst(nrst),
      .word_valid(rx_word_valid),
      .word_in(rx_word),
      .nine_bit_sel(nine_bit_sel),
      .address_detect_en(uart_control_second.address_detect_en),
      .deliver_valid(deliver_valid),
      .deliver_word(deliver_word),
      .addr_pulse(addr_pulse)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Receive pin wake-up; the pin is asynchronous, so two stages first

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         rx_sync <= 2'h3;
         rx_last <= 1'b1;
      end
      else
      begin
         rx_sync <= {rx_sync[0], rx_pin};
         rx_last <= rx_sync[1];
      end
   end

   assign rx_fall = rx_last && !rx_sync[1];

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
         wake_req <= 1'b0;
      else
         wake_req <= rx_fall && low_power_state && uart_control_second.wake_en;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sticky events, cleared by reading status; a new set beats the clear

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
         flags_prev <= 4'h0;
      else
         flags_prev <= {overrun_flag, rx_avail_flag, tx_idle_flag, tx_empty_flag};
   end

   always_comb
   begin
      events.tx_empty = tx_empty_flag && !flags_prev[0];
      events.tx_idle = tx_idle_flag && !flags_prev[1];
      events.rx_avail = rx_avail_flag && !flags_prev[2];
      events.overrun = overrun_flag && !flags_prev[3];
      events.addr_word = addr_pulse;
      events.wake = wake_req;
      // Only bits that the read actually returned are cleared
      rd_clear = (rd && paddr == `UCAID_OFF_STAT) ? prdata[EVT_W-1:0] : '0;
      next_status = (status & ~rd_clear) | events;
   end

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
         status <= `UCAID_STAT_RST;
      else
         status <= next_status;
   end

   always_comb
   begin
      enables.tx_empty = uart_control_second.tx_empty_irq_en;
      enables.tx_idle = uart_control_second.tx_idle_irq_en;
      enables.rx_avail = uart_control_second.rx_irq_en;
      enables.overrun = uart_control_second.rx_irq_en;
      enables.addr_word = uart_control_second.rx_irq_en;
      enables.wake = uart_control_second.wake_en;
   end

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
         uart_irq <= 1'b0;
      else
         uart_irq <= |(next_status & enables & mask);
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);

   property p_wake_edge;
      uart_control_second.wake_en && low_power_state && $fell(rx_sync[1]) |=> wake_req;
   endproperty
   a_wake_edge: assert property (p_wake_edge) else $error("falling edge did not wake");

   property p_no_wake;
      !$past(uart_control_second.wake_en) |-> !wake_req;
   endproperty
   a_no_wake: assert property (p_no_wake) else $error("wake while disabled");

   property p_pin_to_wake;
      uart_control_second.wake_en && low_power_state && rx_pin ##1 !rx_pin [*4]
         ##0 $stable(uart_control_second) && low_power_state |-> $past(wake_req, 1) || wake_req || $past(wake_req, 2);
   endproperty
   a_pin_to_wake: assert property (p_pin_to_wake) else $error("pin fall not seen within three cycles");

   property p_rx_irq;
      $rose(rx_avail_flag) && uart_control_second.rx_irq_en && mask.rx_avail
         && $stable(uart_control_second) |=> uart_irq;
   endproperty
   a_rx_irq: assert property (p_rx_irq) else $error("receive interrupt missing");

   property p_ovr_irq;
      $rose(overrun_flag) && uart_control_second.rx_irq_en && mask.overrun
         && $stable(uart_control_second) |=> uart_irq;
   endproperty
   a_ovr_irq: assert property (p_ovr_irq) else $error("overrun interrupt missing");

   property p_idle_irq;
      $rose(tx_idle_flag) && uart_control_second.tx_idle_irq_en && mask.tx_idle
         && $stable(uart_control_second) |=> uart_irq;
   endproperty
   a_idle_irq: assert property (p_idle_irq) else $error("idle interrupt missing");

   property p_empty_irq;
      $rose(tx_empty_flag) && uart_control_second.tx_empty_irq_en && mask.tx_empty
         && $stable(uart_control_second) |=> uart_irq;
   endproperty
   a_empty_irq: assert property (p_empty_irq) else $error("empty interrupt missing");

   property p_addr_irq;
      rx_word_valid && uart_control_second.address_detect_en && uart_control_second.rx_irq_en
         && mask.addr_word && (nine_bit_sel ? rx_word.rx_bit_nine : rx_word.data[7])
         && $stable(uart_control_second) ##1 $stable(uart_control_second) |=> uart_irq;
   endproperty
   a_addr_irq: assert property (p_addr_irq) else $error("address interrupt missing");

   property p_irq_or;
      uart_irq |-> |($past(next_status) & $past(enables) & $past(mask));
   endproperty
   a_irq_or: assert property (p_irq_or) else $error("interrupt without enabled source");

   property p_disabled_quiet;
      (enables & mask) == '0 [*2] |-> !uart_irq;
   endproperty
   a_disabled_quiet: assert property (p_disabled_quiet) else $error("interrupt with all enables off");

   property p_read_clears;
      rd && paddr == `UCAID_OFF_STAT && prdata[EVT_W-1:0] != '0 && events == '0
         |=> (status & $past(prdata[EVT_W-1:0])) == '0;
   endproperty
   a_read_clears: assert property (p_read_clears) else $error("status read did not clear");

   c_addr_word: cover property (rx_word_valid && uart_control_second.address_detect_en ##2 uart_irq);
   c_wake: cover property (wake_req);
   c_status_read: cover property (rd && paddr == `UCAID_OFF_STAT && prdata != '0);
   c_fast_tick: cover property (uart_control_second.baud_high_speed_sel && baud_tick);

endmodule

// >>> verification/ucaid_remote.sv
// Remote serial transmitter model feeding the receive pin and the received-word strobe
`timescale 1ns/1ps

module ucaid_remote #(
   parameter int BIT = 4
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic send,
   input wire ucaid_pkg::ucaid_word_t word_in,
   output logic rx_pin,
   output logic rx_word_valid,
   output ucaid_pkg::ucaid_word_t rx_word
);
   logic [10:0] shifter;
   logic [3:0] bits_left;
   logic [7:0] cyc;
   ucaid_pkg::ucaid_word_t held;

   ////////////////////////////////////////////////////////////////////////////
   // Frame: start bit, nine data bits lsb first, stop bit; line idles high
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         rx_pin <= 1'b1;
         rx_word_valid <= 1'b0;
         rx_word <= '0;
         held <= '0;
         shifter <= '1;
         bits_left <= 4'h0;
         cyc <= 8'h00;
      end
      else
      begin
         rx_word_valid <= 1'b0;
         // Word bus churns outside the strobe, so a stale value cannot pass
         rx_word <= ~rx_word;
         if (send && bits_left == 4'h0)
         begin
            shifter <= {1'b1, word_in, 1'b0};
            held <= word_in;
            bits_left <= 4'hB;
            cyc <= 8'h00;
         end
         else if (bits_left != 4'h0)
         begin
            rx_pin <= shifter[0];
            if (cyc == 8'(BIT - 1))
            begin
               cyc <= 8'h00;
               shifter <= {1'b1, shifter[10:1]};
               bits_left <= bits_left - 4'h1;
               if (bits_left == 4'h1)
               begin
                  rx_word_valid <= 1'b1;
                  rx_word <= held;
               end
            end
            else
               cyc <= cyc + 8'h01;
         end
         else
            rx_pin <= 1'b1;
      end
   end
endmodule

// >>> verification/ucaid_top_bench.sv
// Self-checking testbench of the UART control block
`timescale 1ns/1ps
`include "ucaid_defines.svh"

module ucaid_top_bench;
   logic clock = 1'b0;
   logic nrst = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic rx_pin;
   logic low_power_state = 1'b0;
   logic rx_word_valid;
   ucaid_pkg::ucaid_word_t rx_word;
   ucaid_pkg::ucaid_word_t send_word = '0;
   logic send = 1'b0;
   logic [3:0] flags = 4'h0;
   logic baud_tick;
   logic nine_bit_sel;
   logic deliver_valid;
   ucaid_pkg::ucaid_word_t deliver_word;
   logic wake_req;
   logic uart_irq;
   logic [31:0] rdv;
   logic errv;
   int num_errors = 0;
   int total_checks = 0;
   int wake_cnt = 0;
   int dlv_cnt = 0;

   ucaid_top #(.DIV_W(8)) ucaid_top_i (.clock(clock), .nrst(nrst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rx_pin(rx_pin), .low_power_state(low_power_state), .rx_word_valid(rx_word_valid), .rx_word(rx_word),
      .rx_avail_flag(flags[2]), .overrun_flag(flags[3]), .tx_idle_flag(flags[1]), .tx_empty_flag(flags[0]),
      .baud_tick(baud_tick), .nine_bit_sel(nine_bit_sel), .deliver_valid(deliver_valid),
      .deliver_word(deliver_word), .wake_req(wake_req), .uart_irq(uart_irq));

   ucaid_remote #(.BIT(4)) ucaid_remote_i (.clock(clock), .nrst(nrst), .send(send), .word_in(send_word),
      .rx_pin(rx_pin), .rx_word_valid(rx_word_valid), .rx_word(rx_word));

   initial
   begin
      forever #2.5 clock = ~clock;
   end

   always @(posedge clock)
   begin
      if (wake_req === 1'b1) wake_cnt++;
      if (deliver_valid === 1'b1) dlv_cnt++;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic print_verdict();
      if (num_errors == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // APB master: request held until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do
      begin
         @(posedge clock);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) num_errors++;
      rdv = prdata;
      errv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic period(output logic [31:0] n);
      int k;
      k = 0;
      do
      begin
         @(posedge clock);
         #1;
         k++;
      end
      while (baud_tick !== 1'b1 && k < 3000);
      if (k >= 3000) num_errors++;
      n = 32'h0;
      do
      begin
         @(posedge clock);
         #1;
         n++;
      end
      while (baud_tick !== 1'b1 && n < 3000);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (20000) @(posedge clock);
      num_errors++;
      print_verdict();
   end

   initial
   begin
      int i;
      int src;
      int k;
      int wake0;
      int dlv0;
      logic [31:0] n;
      logic cfgs [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
      logic dlvs [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
      ucaid_pkg::ucaid_word_t words [5] = '{9'h085, 9'h105, 9'h105, 9'h085, 9'h085};
      logic [3:0] flag_pos [4] = '{4'h8, 4'h4, 4'h1, 4'h2};
      ucaid_pkg::ucaid_word_t last_word;
      repeat (4) @(posedge clock);
      nrst <= 1'b1;
      for (i = 0; i < 5; i++)
      begin
         apb(1'b0, 8'(4 * i), 32'h0);
         check("reset value", rdv, 32'h0);
      end
      apb(1'b0, 8'h1C, 32'h0);
      check("unmapped error", {31'h0, errv}, 32'h1);
      apb(1'b1, `UCAID_OFF_CTRL, 32'hFFFFFFFF);
      apb(1'b0, `UCAID_OFF_CTRL, 32'h0);
      check("control readback", rdv, 32'h3F);
      apb(1'b1, `UCAID_OFF_CFG, 32'h1);
      // Written at the access edge, so look a step later
      #1;
      check("nine bit select", {31'h0, nine_bit_sel}, 32'h1);
      // Bit period at both speeds with divisor one, then the fastest rate
      for (i = 0; i < 3; i++)
      begin
         apb(1'b1, `UCAID_OFF_DIV, (i < 2) ? 32'h1 : 32'h0);
         apb(1'b1, `UCAID_OFF_CTRL, {26'h0, i != 0, 5'h00});
         period(n);
         check("bit period", n, (i == 0) ? 32'h80 : ((i == 1) ? 32'h20 : 32'h10));
      end
      apb(1'b1, `UCAID_OFF_MASK, 32'h3F);
      // Each of the four flag event sources, first disabled then enabled
      for (i = 0; i < 8; i++)
      begin
         src = i % 4;
         apb(1'b1, `UCAID_OFF_CTRL, (i < 4) ? 32'h0 : ((src < 2) ? (32'h1 << src) : 32'h4));
         flags[src] <= 1'b1;
         repeat (3) @(posedge clock);
         #1;
         check("irq on event", {31'h0, uart_irq}, 32'(i >= 4));
         apb(1'b0, `UCAID_OFF_FLAGS, 32'h0);
         check("flag levels", rdv, {28'h0, flag_pos[src]});
         @(posedge clock);
         flags[src] <= 1'b0;
         apb(1'b0, `UCAID_OFF_STAT, 32'h0);
         check("event status", rdv, 32'h1 << src);
         repeat (2) @(posedge clock);
         #1;
         check("irq after clear", {31'h0, uart_irq}, 32'h0);
      end
      // Address filter and wake-up, last frame with wake disabled
      apb(1'b1, `UCAID_OFF_CTRL, 32'h1C);
      for (i = 0; i < 5; i++)
      begin
         if (i == 4) apb(1'b1, `UCAID_OFF_CTRL, 32'h14);
         apb(1'b1, `UCAID_OFF_CFG, {31'h0, cfgs[i]});
         apb(1'b0, `UCAID_OFF_STAT, 32'h0);
         wake0 = wake_cnt;
         dlv0 = dlv_cnt;
         // Asleep before each frame; the first wake pulse ends the sleep
         low_power_state <= 1'b1;
         send_word <= words[i];
         send <= 1'b1;
         @(posedge clock);
         send <= 1'b0;
         k = 0;
         while (rx_word_valid !== 1'b1 && k < 200)
         begin
            @(posedge clock);
            if (wake_req === 1'b1) low_power_state <= 1'b0;
            #1;
            k++;
         end
         if (rx_word_valid !== 1'b1) num_errors++;
         repeat (3) @(posedge clock);
         #1;
         check("delivered count", 32'(dlv_cnt - dlv0), {31'h0, dlvs[i]});
         if (dlvs[i]) check("delivered word", {23'h0, deliver_word}, {23'h0, words[i]});
         if (dlvs[i]) check("address irq", {31'h0, uart_irq}, 32'h1);
         check("wake pulses", 32'(wake_cnt - wake0), 32'(i < 4));
         if (dlvs[i]) last_word = words[i];
         apb(1'b0, `UCAID_OFF_RXD, 32'h0);
         check("receive data", rdv, {23'h0, last_word});
         apb(1'b0, `UCAID_OFF_STAT, 32'h0);
         check("address and wake status", rdv & 32'h30, {26'h0, i < 4, dlvs[i], 4'h0});
      end
      print_verdict();
   end
endmodule
